/* File: design/err_bank_pkg.sv */
// Constants and types shared by the error status bank and its duty meter
package err_bank_pkg;
    // Register offsets on the serial register port
    localparam logic [7:0] ADDR_CPU1_THR = 8'h44;
    localparam logic [7:0] ADDR_CPU2_THR = 8'h45;
    localparam logic [7:0] ADDR_GPI_ERR = 8'h46;
    localparam logic [7:0] ADDR_FAN_ERR = 8'h47;
    // Values after reset
    localparam logic [7:0] RESET_STATUS = 8'h00;
    // Fan register layout: four live bits, upper nibble reserved
    localparam int FAN_COUNT = 4;
    localparam int FAN_TACH_W = 16;
    localparam logic [3:0] FAN_RESERVED = 4'h0;
    // Throttle register field positions
    localparam int BIT_ANY_THROTTLE = 0;
    localparam int BIT_FULL_THROTTLE = 6;
    localparam int BIT_LIMIT = 7;
    // Duty measurement: 256 samples per period, one sample is 1/256 = 0.39 %
    localparam int CLK_NS = 20;
    localparam int SAMPLE_NS = 1000;
    localparam int SAMPLE_CYCLES = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] LAST_SAMPLE = 8'hff;
    // Duty bin edges in samples out of 256
    localparam logic [8:0] DUTY_12P5 = 9'h020;
    localparam logic [8:0] DUTY_25 = 9'h040;
    localparam logic [8:0] DUTY_50 = 9'h080;
    localparam logic [8:0] DUTY_75 = 9'h0c0;
    localparam logic [8:0] DUTY_100 = 9'h100;
    localparam logic [8:0] DUTY_MIN_CPU1 = 9'h001;
    localparam logic [8:0] DUTY_MIN_CPU2 = 9'h000;
    // System sleep state as reported by the sleep control logic
    typedef enum logic [1:0]
    {
        SLEEP_S0 = 2'b00,
        SLEEP_S1 = 2'b01,
        SLEEP_S3 = 2'b10,
        SLEEP_S45 = 2'b11
    } sleep_t;
endpackage

/* File: design/duty_meter.sv */
// Throttle duty meter: counts asserted samples over a 256-sample period
`timescale 1ns/1ps
module duty_meter
    import err_bank_pkg::*;
#(
    parameter logic [8:0] LOW_MIN = 9'h001
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Sample strobe and throttle level
    input wire logic sample_en_i,
    input wire logic throttle_i,
    input wire logic [7:0] limit_i,
    // Held result of the last period: low, 12-25, 25-50, 50-75, 75-100, full, over limit
    output logic [6:0] flags_o
);
    typedef struct packed {
        logic [7:0] idx;    // Sample index within the period
        logic [8:0] high;   // Asserted samples seen so far
        logic [6:0] flags;  // Result of the last finished period
    } meter_t;

    meter_t st;
    meter_t next_st;
    logic [8:0] total;

    // Count samples; at the last one classify the duty and restart
    always_comb
    begin
        next_st = st;
        total = st.high + {8'h00, throttle_i};
        if (sample_en_i)
        begin
            next_st.idx = st.idx + 8'h01;
            next_st.high = total;
            if (st.idx == LAST_SAMPLE)
            begin
                next_st.high = 9'h000;
                next_st.flags[0] = (total >= LOW_MIN) && (total < DUTY_12P5);
                next_st.flags[1] = (total >= DUTY_12P5) && (total < DUTY_25);
                next_st.flags[2] = (total >= DUTY_25) && (total < DUTY_50);
                next_st.flags[3] = (total >= DUTY_50) && (total < DUTY_75);
                next_st.flags[4] = (total >= DUTY_75) && (total < DUTY_100);
                next_st.flags[5] = (total == DUTY_100);
                next_st.flags[6] = (total > {1'b0, limit_i});
            end
        end
    end

    // State register, synchronous reset
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign flags_o = st.flags;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Helper: period end with the totals it classified
    logic period_end;
    assign period_end = sample_en_i && (st.idx == LAST_SAMPLE);

    full_period_a: assert property (period_end && total == DUTY_100 |=> flags_o[5]) // R4
        else $error("full throttle period not flagged");
    over_limit_a: assert property ( // R5
        period_end |=> flags_o[6] == ($past(total) > {1'b0, $past(limit_i)}))
        else $error("limit flag disagrees with measured duty");
    bin_low_a: assert property ( // R2
        period_end && total >= LOW_MIN && total < DUTY_12P5 |=> flags_o[0])
        else $error("low duty bin not flagged");
    bin_mid_a: assert property ( // R3
        period_end && total >= DUTY_25 && total < DUTY_50 |=> flags_o[2] && !flags_o[3])
        else $error("25-50 duty bin wrong");
endmodule // duty_meter

/* File: design/bmc_error_status_bank.sv */
// Sticky write-one-to-clear error status bank for the management controller
// How it works
// R1 - Bit 0 sets on any throttling
// R2 - CPU1 bit 1: duty 0.39 to 12.5 percent
// R3 - Bits 2-5: four duty bins, lower inclusive
// R4 - Bit 6 sets at full-period throttle
// R5 - Bit 7 sets when duty exceeds limit
// R6 - Of the throttle bits only the limit bit feeds the summary; any input or fan error bit feeds it too
// R7 - CPU2 same layout, low bin from zero
// R8 - Input error n sets on low pin
// R9 - Fan error sets when count exceeds limit
// R10 - Throttle events masked in S3, S4/5
// R11 - Input errors optionally masked S1, S3, S4/5
// R12 - Fan errors optional S1, S3; always S4/5
// R13 - Write one clears, zero keeps
// R14 - Set bits stay until software clears
// R15 - Clear ignored while condition still present
// R16 - Starred states mask only when enabled
// R17 - Reset to zero; fan reserved bits zero
`timescale 1ns/1ps
module bmc_error_status_bank
    import err_bank_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Processor throttle inputs and user duty limits (samples out of 256)
    input wire logic cpu1_throttle_input_i,
    input wire logic cpu2_throttle_input_i,
    input wire logic [7:0] cpu1_duty_limit_i,
    input wire logic [7:0] cpu2_duty_limit_i,
    // General purpose pins and their error mask
    input wire logic [7:0] general_io_pin_i,
    input wire logic [7:0] gpi_err_mask_i,
    // Fan tachometer counts and limits
    input wire logic [FAN_COUNT-1:0][FAN_TACH_W-1:0] fan_tach_count_i,
    input wire logic [FAN_COUNT-1:0][FAN_TACH_W-1:0] fan_tach_limit_i,
    // Sleep state and sleep mask enables
    input wire logic [1:0] sleep_state_i,
    input wire logic [2:0] gpi_sleep_mask_i,
    input wire logic [1:0] fan_sleep_mask_i,
    // Register port from the serial interface
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Summary error toward the status/control register
    output logic mgmt_summary_error_o
);
    typedef struct packed {
        logic [7:0] cpu1;     // cpu1_throttle_status
        logic [7:0] cpu2;     // cpu2_throttle_status
        logic [7:0] gpi;      // general_input_error_status
        logic [3:0] fan;      // fan_tach_error_status, live bits only
        logic [7:0] rdata;    // Registered read data
        logic summary;        // Registered summary error
        logic [5:0] div;      // Sample divider
    } bank_t;

    bank_t st;
    bank_t next_st;
    sleep_t sleep;
    logic sample_en;
    logic [6:0] cpu1_flags;
    logic [6:0] cpu2_flags;
    logic thr_awake;       // Throttle events allowed
    logic gpi_sleep_mask;  // Input errors masked by sleep
    logic fan_sleep_mask;  // Fan errors masked by sleep
    logic [7:0] cpu1_ev;
    logic [7:0] cpu2_ev;
    logic [7:0] gpi_ev;
    logic [3:0] fan_raw;
    logic [3:0] fan_ev;

    assign sleep = sleep_t'(sleep_state_i);

    // One-cycle sample strobe; slow enough that a period spans many clocks
    assign sample_en = (st.div == 6'(SAMPLE_CYCLES - 1));

    // CPU1 low bin starts above zero, CPU2 low bin includes zero
    duty_meter #(.LOW_MIN(DUTY_MIN_CPU1)) u_meter1 ( // R2
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .sample_en_i(sample_en),
        .throttle_i(cpu1_throttle_input_i),
        .limit_i(cpu1_duty_limit_i),
        .flags_o(cpu1_flags)
    );
    duty_meter #(.LOW_MIN(DUTY_MIN_CPU2)) u_meter2 ( // R7
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .sample_en_i(sample_en),
        .throttle_i(cpu2_throttle_input_i),
        .limit_i(cpu2_duty_limit_i),
        .flags_o(cpu2_flags)
    );

    // Fan comparators, one per tachometer
    genvar n;
    generate
        for (n = 0; n < FAN_COUNT; n++)
        begin : g_fan
            assign fan_raw[n] = fan_tach_count_i[n] > fan_tach_limit_i[n]; // R9
        end
    endgenerate

    // Sleep masking and event levels; events stay high while the cause lasts
    always_comb
    begin
        thr_awake = !(sleep == SLEEP_S3 || sleep == SLEEP_S45); // R10
        gpi_sleep_mask = (sleep == SLEEP_S1 && gpi_sleep_mask_i[0]) // R11 R16
            || (sleep == SLEEP_S3 && gpi_sleep_mask_i[1])
            || (sleep == SLEEP_S45 && gpi_sleep_mask_i[2]);
        fan_sleep_mask = (sleep == SLEEP_S1 && fan_sleep_mask_i[0]) // R12 R16
            || (sleep == SLEEP_S3 && fan_sleep_mask_i[1])
            || (sleep == SLEEP_S45);
        cpu1_ev = {cpu1_flags, cpu1_throttle_input_i} & {8{thr_awake}}; // R1 R3 R4 R5
        cpu2_ev = {cpu2_flags, cpu2_throttle_input_i} & {8{thr_awake}}; // R7
        gpi_ev = ~general_io_pin_i & ~gpi_err_mask_i & {8{!gpi_sleep_mask}}; // R8
        fan_ev = fan_raw & {4{!fan_sleep_mask}};
    end

    // Register update: clear by write-one, set wins over clear
    always_comb
    begin
        next_st = st;
        next_st.div = sample_en ? 6'h00 : st.div + 6'h01;
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                ADDR_CPU1_THR: next_st.cpu1 = st.cpu1 & ~reg_wdata_i; // R13
                ADDR_CPU2_THR: next_st.cpu2 = st.cpu2 & ~reg_wdata_i;
                ADDR_GPI_ERR: next_st.gpi = st.gpi & ~reg_wdata_i;
                ADDR_FAN_ERR: next_st.fan = st.fan & ~reg_wdata_i[3:0]; // R17
                default: ; // Writes elsewhere are ignored
            endcase
        end
        // A present condition re-sets the bit, so a clear cannot drop it
        next_st.cpu1 = next_st.cpu1 | cpu1_ev; // R14 R15
        next_st.cpu2 = next_st.cpu2 | cpu2_ev;
        next_st.gpi = next_st.gpi | gpi_ev;
        next_st.fan = next_st.fan | fan_ev;
        // Read data is the value before this cycle's update
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                ADDR_CPU1_THR: next_st.rdata = st.cpu1;
                ADDR_CPU2_THR: next_st.rdata = st.cpu2;
                ADDR_GPI_ERR: next_st.rdata = st.gpi;
                ADDR_FAN_ERR: next_st.rdata = {FAN_RESERVED, st.fan}; // R17
                default: next_st.rdata = RESET_STATUS; // Unmapped reads as zero
            endcase
        end
        // Duty bins and full-throttle bits never reach the summary
        next_st.summary = next_st.cpu1[BIT_LIMIT] | next_st.cpu2[BIT_LIMIT] // R6
            | (|next_st.gpi) | (|next_st.fan);
    end

    // State register, synchronous reset to zero
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            st <= '0; // R17
        else
            st <= next_st;
    end

    assign reg_rdata_o = st.rdata;
    assign mgmt_summary_error_o = st.summary;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Any write to the input error register, whatever the data
    sequence gpi_write;
        reg_wr_i && reg_addr_i == ADDR_GPI_ERR;
    endsequence

    // Any register write; a present event must still win over its clear
    sequence any_write;
        reg_wr_i;
    endsequence

    // Event to status bit
    any_throttle_a: assert property (cpu1_throttle_input_i && thr_awake |=> st.cpu1[0]) // R1
        else $error("any-throttle bit not set");
    // Clear and sticky behaviour: clears checked for any write data rather than one value, sticky bits on every cycle without a cpu1 write
    sticky_bits_a: assert property ( // R14
        !(reg_wr_i && reg_addr_i == ADDR_CPU1_THR) |=> ($past(st.cpu1) & ~st.cpu1) == 8'h00)
        else $error("throttle bit dropped without a clear");
    zero_write_a: assert property ( // R13
        gpi_write |=> ($past(st.gpi) & ~$past(reg_wdata_i) & ~st.gpi) == 8'h00)
        else $error("writing zero changed a bit");
    clear_works_a: assert property ( // R13
        gpi_write |=> (st.gpi & $past(reg_wdata_i) & ~$past(gpi_ev)) == 8'h00)
        else $error("write-one did not clear");
    clear_blocked_a: assert property ( // R15
        any_write |=> ($past(gpi_ev) & ~st.gpi) == 8'h00 && ($past(fan_ev) & ~st.fan) == 4'h0)
        else $error("bit cleared while condition present");
    pin_low_a: assert property ( // R8
        !general_io_pin_i[2] && !gpi_err_mask_i[2] && !gpi_sleep_mask |=> st.gpi[2])
        else $error("input error not set on low pin");
    fan_over_a: assert property (fan_raw[0] && sleep == SLEEP_S0 |=> st.fan[0]) // R9
        else $error("fan error not set");
    // Sleep masking, watched from the sleep input itself
    thr_sleep_a: assert property ( // R10
        sleep == SLEEP_S3 || sleep == SLEEP_S45
        |=> ((st.cpu1 & ~$past(st.cpu1)) | (st.cpu2 & ~$past(st.cpu2))) == 8'h00)
        else $error("throttle bit set while asleep");
    gpi_sleep_a: assert property ( // R11
        sleep == SLEEP_S1 && gpi_sleep_mask_i[0] |=> (st.gpi & ~$past(st.gpi)) == 8'h00)
        else $error("input error set in masked S1");
    fan_s45_a: assert property (sleep == SLEEP_S45 |=> (st.fan & ~$past(st.fan)) == 4'h0) // R12
        else $error("fan error set in S4/5");
    // Summary and read-back
    summary_limit_a: assert property ( // R6
        st.cpu1[BIT_LIMIT] || st.cpu2[BIT_LIMIT] |-> mgmt_summary_error_o)
        else $error("limit bit did not raise the summary");
    summary_src_a: assert property ( // R6
        !st.cpu1[BIT_LIMIT] && !st.cpu2[BIT_LIMIT] && st.gpi == 8'h00 && st.fan == 4'h0
        |-> !mgmt_summary_error_o)
        else $error("summary follows a non-limit bit");
    reserved_read_a: assert property ( // R17
        reg_rd_i && reg_addr_i == ADDR_FAN_ERR |=> reg_rdata_o[7:4] == 4'h0)
        else $error("reserved fan bits read nonzero");
endmodule // bmc_error_status_bank

/* File: sim/mgmt_port_model.sv */
// Management controller model driving the bank's register port
`timescale 1ns/1ps
module mgmt_port_model
(
    // Clock
    input wire logic clk_i,
    // Register port toward the bank
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    // Quiet port at time zero
    initial
    begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // One-cycle write; released lines flip so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    end
    endtask
    // One-cycle read; data is taken once the read edge has registered it
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
    begin
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        @(negedge clk_i);
        q = reg_rdata_i;
    end
    endtask
endmodule // mgmt_port_model

/* File: sim/bmc_error_status_bank_tb.sv */
// Self-checking bench for the error status bank
`timescale 1ns/1ps
module bmc_error_status_bank_tb;
    import err_bank_pkg::*;
    // Clock, reset and event sources
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic thr1 = 1'b0;
    logic thr2 = 1'b0;
    logic [7:0] pins = 8'hff;
    logic [7:0] gmask = 8'h00;
    logic [FAN_COUNT-1:0][FAN_TACH_W-1:0] cnt = {4{16'h0100}};
    logic [FAN_COUNT-1:0][FAN_TACH_W-1:0] lim = {4{16'h0100}};
    sleep_t slp = SLEEP_S0;
    logic [2:0] gslp = 3'h0;
    logic [1:0] fslp = 2'h0;
    // Duty limits; cpu2 idles at a duty equal to its limit, which is not an excess
    logic [7:0] duty_lim1 = 8'hff;
    logic [7:0] duty_lim2 = 8'h00;
    // Register port and results
    logic [7:0] addr, wdata, rdata, q;
    logic wr, rd, summ;
    int bad_count = 0;
    int checks = 0;
    // 50 MHz clock
    always #10 clk_i = ~clk_i;
    // Bank under test
    bmc_error_status_bank bmc_error_status_bank_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .cpu1_throttle_input_i(thr1), .cpu2_throttle_input_i(thr2),
        .cpu1_duty_limit_i(duty_lim1), .cpu2_duty_limit_i(duty_lim2),
        .general_io_pin_i(pins), .gpi_err_mask_i(gmask),
        .fan_tach_count_i(cnt), .fan_tach_limit_i(lim), .sleep_state_i(slp),
        .gpi_sleep_mask_i(gslp), .fan_sleep_mask_i(fslp), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .mgmt_summary_error_o(summ));
    // Controller on the far side
    mgmt_port_model mgmt_port_model_inst (.clk_i(clk_i), .reg_addr_o(addr),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
    // Compare one byte, four-state exact
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    begin
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    end
    endtask
    // Read a register and compare
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string n);
    begin
        mgmt_port_model_inst.rd(a, q);
        chk(n, e, q);
    end
    endtask
    // Verdict and end of run
    task automatic summarize;
    begin
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    // Watchdog sized for three two-period throttle waits plus margin
    initial
    begin
        repeat (85000) @(posedge clk_i);
        bad_count++;
        summarize();
    end
    // Test sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        rdchk(ADDR_CPU1_THR, 8'h00, "cpu1 reset");
        rdchk(ADDR_GPI_ERR, 8'h00, "gpi reset");
        rdchk(ADDR_FAN_ERR, 8'h00, "fan reset");
        rdchk(8'h48, 8'h00, "unmapped");
        $display("test reset done");
        // Pins 2 and 4 low, pin 4 masked
        @(posedge clk_i);
        pins <= 8'heb;
        gmask <= 8'h10;
        rdchk(ADDR_GPI_ERR, 8'h04, "gpi set");
        chk("summary", 8'h01, {7'h00, summ});
        mgmt_port_model_inst.wr(ADDR_GPI_ERR, 8'h04);
        rdchk(ADDR_GPI_ERR, 8'h04, "gpi held");
        @(posedge clk_i);
        pins <= 8'hff;
        rdchk(ADDR_GPI_ERR, 8'h04, "gpi sticky");
        mgmt_port_model_inst.wr(ADDR_GPI_ERR, 8'hfb);
        rdchk(ADDR_GPI_ERR, 8'h04, "gpi zero write");
        mgmt_port_model_inst.wr(ADDR_GPI_ERR, 8'h04);
        rdchk(ADDR_GPI_ERR, 8'h00, "gpi cleared");
        // Each optional sleep state masks only with its enable set
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_i);
            slp <= sleep_t'(i + 1);
            gslp <= 3'h1 << i;
            pins <= 8'hfe;
            rdchk(ADDR_GPI_ERR, 8'h00, "gpi slept");
            @(posedge clk_i);
            gslp <= 3'h0;
            rdchk(ADDR_GPI_ERR, 8'h01, "gpi awake");
            @(posedge clk_i);
            pins <= 8'hff;
            mgmt_port_model_inst.wr(ADDR_GPI_ERR, 8'h01);
        end
        $display("test gpi done");
        // Fan 0 one above limit, others equal to limit
        @(posedge clk_i);
        slp <= SLEEP_S0;
        cnt[0] <= 16'h0101;
        rdchk(ADDR_FAN_ERR, 8'h01, "fan set");
        @(posedge clk_i);
        cnt[0] <= 16'h0100;
        mgmt_port_model_inst.wr(ADDR_FAN_ERR, 8'hf0);
        rdchk(ADDR_FAN_ERR, 8'h01, "fan reserved");
        mgmt_port_model_inst.wr(ADDR_FAN_ERR, 8'h01);
        rdchk(ADDR_FAN_ERR, 8'h00, "fan cleared");
        // Deep sleep masks fan events whatever the enables say
        @(posedge clk_i);
        slp <= SLEEP_S45;
        fslp <= 2'h0;
        cnt[3] <= 16'h0101;
        rdchk(ADDR_FAN_ERR, 8'h00, "fan deep sleep");
        @(posedge clk_i);
        slp <= SLEEP_S1;
        fslp <= 2'h1;
        rdchk(ADDR_FAN_ERR, 8'h00, "fan S1 masked");
        @(posedge clk_i);
        slp <= SLEEP_S3;
        fslp <= 2'h2;
        rdchk(ADDR_FAN_ERR, 8'h00, "fan S3 masked");
        @(posedge clk_i);
        slp <= SLEEP_S1;
        rdchk(ADDR_FAN_ERR, 8'h08, "fan light sleep");
        @(posedge clk_i);
        cnt[3] <= 16'h0100;
        mgmt_port_model_inst.wr(ADDR_FAN_ERR, 8'h08);
        $display("test fan done");
        // Full throttle during S3 is ignored; two periods cover one whole one
        @(posedge clk_i);
        slp <= SLEEP_S3;
        thr1 <= 1'b1;
        repeat (25700) @(posedge clk_i);
        rdchk(ADDR_CPU1_THR, 8'h00, "cpu1 slept");
        rdchk(ADDR_CPU2_THR, 8'h00, "cpu2 slept");
        @(posedge clk_i);
        slp <= SLEEP_S0;
        repeat (25700) @(posedge clk_i);
        rdchk(ADDR_CPU1_THR, 8'hc1, "cpu1 full");
        rdchk(ADDR_CPU2_THR, 8'h02, "cpu2 idle");
        chk("summary", 8'h01, {7'h00, summ});
        // Idle periods: limit bit cleared, bin bit alone keeps summary low
        @(posedge clk_i);
        thr1 <= 1'b0;
        repeat (25700) @(posedge clk_i);
        mgmt_port_model_inst.wr(ADDR_CPU1_THR, 8'hff);
        rdchk(ADDR_CPU1_THR, 8'h00, "cpu1 cleared");
        chk("summary", 8'h00, {7'h00, summ});
        $display("test throttle done");
        // Mid-run reset drops the standing cpu2 bin bit
        rdchk(ADDR_CPU2_THR, 8'h02, "cpu2 bin held");
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        rdchk(ADDR_CPU2_THR, 8'h00, "cpu2 after reset");
        chk("summary reset", 8'h00, {7'h00, summ});
        $display("test mid reset done");
        summarize();
    end
endmodule // bmc_error_status_bank_tb
